// ### verilog/radio_host_api_framer.sv
// Host API framer: transmit frame routing, status reports and receive frames
// What this block does
// - With status reporting on, a report goes to the host once the packet is acked or attempts run out.
// - The report is four bytes: tag 82h, result 00h fail or 01h success, remote strength, local strength.
// - For a non-broadcast packet, the result byte follows whether a valid acknowledgement came back from the remote unit.
// - A broadcast packet always reports success once its repetitions are used up.
// - With receive framing on, each packet reaches the host as tag, length, both strengths, address 2,1,0, payload.
// - Transmit framing, status reporting and receive framing switch on independently in any mix.
// - A pending status report goes out before any later receive frame, unless it arrives mid-frame.
// - With transmit framing on, per-packet routing overrides the configured delivery mode.
// - The host serial rate defaults to 57600 baud unless configured otherwise.
// - Configuration takes effect only when the block leaves reset, standing for a power cycle.
// - A transmit frame addressed to FFh FFh FFh is sent as a broadcast.
`timescale 1ns/10ps
module radio_host_api_framer
   import api_framer_pkg::*;
#(
   parameter int MAX_LEN = 128
) (
   // Clock, reset, enable
   input wire logic i_sys_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Configuration, sampled once after reset
   input wire logic i_cfg_tx_api_en,
   input wire logic i_cfg_status_en,
   input wire logic i_cfg_rx_api_en,
   input wire logic [1:0] i_cfg_route_mode,
   input wire logic [23:0] i_cfg_dest_addr,
   input wire logic [7:0] i_cfg_max_retries,
   input wire logic [7:0] i_cfg_bcast_attempts,
   input wire logic i_cfg_baud_set,
   input wire logic [23:0] i_cfg_baud_rate,
   output logic [23:0] o_baud_rate,
   // Host to block byte stream
   input wire logic i_host_in_valid,
   input wire logic [7:0] i_host_in_data,
   output logic o_host_in_ready,
   // Block to host byte stream
   output logic o_host_out_valid,
   output logic [7:0] o_host_out_data,
   input wire logic i_host_out_ready,
   // Radio transmit bytes with route
   output logic o_rf_tx_valid,
   output logic [7:0] o_rf_tx_data,
   output logic o_rf_tx_last,
   output logic [23:0] o_rf_tx_dest,
   output logic o_rf_tx_bcast,
   output logic [7:0] o_rf_tx_attempts,
   output logic [7:0] o_rf_tx_session,
   input wire logic i_rf_tx_ready,
   // Radio transmit result
   input wire logic i_tx_done,
   input wire logic i_tx_acked,
   input wire logic i_tx_was_bcast,
   input wire logic [7:0] i_tx_remote_heard_local_strength,
   input wire logic [7:0] i_tx_local_heard_remote_strength,
   // Radio receive packet
   input wire logic i_rx_start,
   input wire logic [7:0] i_rx_len,
   input wire logic [7:0] i_rx_remote_heard_local_strength,
   input wire logic [7:0] i_rx_local_heard_remote_strength,
   input wire logic [23:0] i_rx_src_addr,
   output logic o_rx_hdr_ready,
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   output logic o_rx_ready
);
   typedef struct packed {
      host_st_t hst;
      logic [2:0] idx;
      logic [7:0] rem;
      logic loaded;
      logic c_txapi;
      logic c_stat;
      logic c_rxapi;
      logic [1:0] c_mode;
      logic [23:0] c_dest;
      logic [7:0] c_retry;
      logic [7:0] c_bcnt;
      logic [23:0] baud;
      logic stat_pend;
      logic [7:0] st_res;
      logic [7:0] st_rem;
      logic [7:0] st_loc;
      logic rx_pend;
      logic [7:0] rx_len;
      logic [7:0] rx_rem;
      logic [7:0] rx_loc;
      logic [23:0] rx_src;
      logic learned;
      logic [23:0] auto_dest;
      logic [23:0] r_dest;
      logic [7:0] r_att;
      logic [7:0] r_ses;
      logic r_bc;
      logic hv;
      logic [7:0] hd;
      logic rx_rdy;
      logic rxh_rdy;
      logic fv;
      logic [7:0] fd;
      logic fl;
      logic fbc;
      logic [23:0] fdst;
      logic [7:0] fatt;
      logic [7:0] fses;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic load;
   tx_hdr_if hif ();

   tx_frame_parser #(.MAX_LEN(MAX_LEN)) u_parser (
      .clk(i_sys_clk),
      .nrst(i_nrst),
      .ce(i_ce),
      .api_en(s_r.c_txapi),
      .byte_valid(i_host_in_valid),
      .byte_data(i_host_in_data),
      .byte_ready(o_host_in_ready),
      .hif(hif.parser)
   );

   assign hif.pay_ready = !s_r.fv || i_rf_tx_ready;

   always_comb begin
      s_nxt = s_r;
      load = !s_r.hv || i_host_out_ready;
      // Captured once only; later pin changes wait for the next reset
      if (!s_r.loaded) begin
         s_nxt.loaded = 1'b1;
         s_nxt.c_txapi = i_cfg_tx_api_en;
         s_nxt.c_stat = i_cfg_status_en;
         s_nxt.c_rxapi = i_cfg_rx_api_en;
         s_nxt.c_mode = i_cfg_route_mode;
         s_nxt.c_dest = i_cfg_dest_addr;
         s_nxt.c_retry = i_cfg_max_retries;
         s_nxt.c_bcnt = i_cfg_bcast_attempts;
         s_nxt.baud = i_cfg_baud_set ? i_cfg_baud_rate : DEF_BAUD;
      end
      // Transmit side: route snapshot travels with every byte
      if (s_r.fv && i_rf_tx_ready) begin
         s_nxt.fv = 1'b0;
      end
      if (hif.hdr_valid) begin
         s_nxt.r_dest = hif.dest;
         s_nxt.r_att = hif.attempts;
         s_nxt.r_ses = hif.session;
         s_nxt.r_bc = (hif.dest == BCAST_ADDR);
      end
      if (hif.pay_valid && hif.pay_ready) begin
         s_nxt.fv = 1'b1;
         s_nxt.fd = hif.pay_data;
         s_nxt.fl = hif.pay_last;
         if (!hif.pay_raw) begin
            s_nxt.fdst = s_r.r_dest;
            s_nxt.fbc = s_r.r_bc;
            s_nxt.fatt = s_r.r_att;
            s_nxt.fses = s_r.r_ses;
         end else begin
            s_nxt.fses = 8'h00;
            case (s_r.c_mode)
               MODE_BCAST: begin
                  s_nxt.fdst = BCAST_ADDR;
                  s_nxt.fbc = 1'b1;
                  s_nxt.fatt = s_r.c_bcnt;
               end
               MODE_AUTO: begin
                  s_nxt.fdst = s_r.auto_dest;
                  s_nxt.fbc = 1'b0;
                  s_nxt.fatt = s_r.c_retry;
               end
               default: begin
                  s_nxt.fdst = s_r.c_dest;
                  s_nxt.fbc = 1'b0;
                  s_nxt.fatt = s_r.c_retry;
               end
            endcase
         end
      end
      // Host output side
      if (s_r.hv && i_host_out_ready) begin
         s_nxt.hv = 1'b0;
      end
      case (s_r.hst)
         H_IDLE: begin
            // Report ahead of a waiting receive frame
            if (s_r.stat_pend) begin
               s_nxt.hst = H_STAT;
               s_nxt.idx = 3'h0;
            end else if (s_r.rx_pend) begin
               s_nxt.hst = s_r.c_rxapi ? H_RXHDR : H_RXPAY;
               s_nxt.idx = 3'h0;
               s_nxt.rem = s_r.rx_len;
            end
         end
         H_STAT: begin
            if (load) begin
               s_nxt.hv = 1'b1;
               case (s_r.idx)
                  3'h0: s_nxt.hd = TAG_STATUS;
                  3'h1: s_nxt.hd = s_r.st_res;
                  3'h2: s_nxt.hd = s_r.st_rem;
                  default: s_nxt.hd = s_r.st_loc;
               endcase
               s_nxt.idx = s_r.idx + 3'h1;
               if (s_r.idx == STAT_LAST_IDX) begin
                  s_nxt.hst = H_IDLE;
                  s_nxt.stat_pend = 1'b0;
               end
            end
         end
         H_RXHDR: begin
            if (load) begin
               s_nxt.hv = 1'b1;
               case (s_r.idx)
                  3'h0: s_nxt.hd = TAG_FRAME;
                  3'h1: s_nxt.hd = s_r.rx_len;
                  3'h2: s_nxt.hd = s_r.rx_rem;
                  3'h3: s_nxt.hd = s_r.rx_loc;
                  3'h4: s_nxt.hd = s_r.rx_src[23:16];
                  3'h5: s_nxt.hd = s_r.rx_src[15:8];
                  default: s_nxt.hd = s_r.rx_src[7:0];
               endcase
               s_nxt.idx = s_r.idx + 3'h1;
               if (s_r.idx == RXHDR_LAST_IDX) begin
                  s_nxt.hst = H_RXPAY;
               end
            end
         end
         H_RXPAY: begin
            if (s_r.rem == 8'h00) begin
               s_nxt.hst = H_IDLE;
               s_nxt.rx_pend = 1'b0;
            end else if (i_rx_valid && s_r.rx_rdy) begin
               s_nxt.hv = 1'b1;
               s_nxt.hd = i_rx_data;
               s_nxt.rem = s_r.rem - 8'h01;
            end
         end
         default: s_nxt.hst = H_IDLE;
      endcase
      // Sets after the clears so a same-cycle event is kept
      if (i_tx_done && s_r.c_stat) begin
         s_nxt.stat_pend = 1'b1;
         s_nxt.st_res = (i_tx_was_bcast || i_tx_acked) ? RES_OK : RES_FAIL;
         s_nxt.st_rem = i_tx_remote_heard_local_strength;
         s_nxt.st_loc = i_tx_local_heard_remote_strength;
      end
      if (i_rx_start && s_r.rxh_rdy) begin
         s_nxt.rx_pend = 1'b1;
         s_nxt.rx_len = i_rx_len;
         s_nxt.rx_rem = i_rx_remote_heard_local_strength;
         s_nxt.rx_loc = i_rx_local_heard_remote_strength;
         s_nxt.rx_src = i_rx_src_addr;
         if (!s_r.learned) begin
            s_nxt.learned = 1'b1;
            s_nxt.auto_dest = i_rx_src_addr;
         end
      end
      s_nxt.rx_rdy = (s_nxt.hst == H_RXPAY) && !s_nxt.hv && (s_nxt.rem != 8'h00);
      s_nxt.rxh_rdy = !s_nxt.rx_pend;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_nrst) begin
         s_r <= '{hst: H_IDLE, c_dest: 24'h000000, baud: DEF_BAUD, default: '0};
      end else if (i_ce) begin
         s_r <= s_nxt;
      end
   end

   assign o_baud_rate = s_r.baud;
   assign o_host_out_valid = s_r.hv;
   assign o_host_out_data = s_r.hd;
   assign o_rf_tx_valid = s_r.fv;
   assign o_rf_tx_data = s_r.fd;
   assign o_rf_tx_last = s_r.fl;
   assign o_rf_tx_dest = s_r.fdst;
   assign o_rf_tx_bcast = s_r.fbc;
   assign o_rf_tx_attempts = s_r.fatt;
   assign o_rf_tx_session = s_r.fses;
   assign o_rx_hdr_ready = s_r.rxh_rdy;
   assign o_rx_ready = s_r.rx_rdy;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   AST_STAT_TAG: assert property (i_ce && s_r.hst == H_STAT && s_r.idx == 3'h0 && load
      |=> o_host_out_valid && o_host_out_data == TAG_STATUS)
      else $error("status frame does not open with its tag");
   AST_STAT_RESULT: assert property (i_ce && i_tx_done && s_r.c_stat
      |=> s_r.stat_pend
      && s_r.st_res == (($past(i_tx_acked) || $past(i_tx_was_bcast)) ? RES_OK : RES_FAIL))
      else $error("status result does not follow acknowledgement");
   AST_BCAST_OK: assert property (i_ce && i_tx_done && i_tx_was_bcast && s_r.c_stat
      |=> s_r.st_res == RES_OK)
      else $error("broadcast report not success");
   AST_NO_REPORT: assert property (i_ce && i_tx_done && !s_r.c_stat && !s_r.stat_pend
      |=> !s_r.stat_pend)
      else $error("report raised while reporting disabled");
   AST_REPORT_FIRST: assert property (i_ce && s_r.hst == H_IDLE && s_r.stat_pend
      |=> s_r.hst == H_STAT)
      else $error("receive frame overtook a pending report");
   AST_STAT_LEN: assert property (i_ce && s_r.hst == H_STAT && s_r.idx == STAT_LAST_IDX && load
      |=> s_r.hst == H_IDLE && o_host_out_data == $past(s_r.st_loc))
      else $error("status frame not four bytes");
   AST_RX_ADDR: assert property (i_ce && s_r.hst == H_RXHDR && s_r.idx == 3'h4 && load
      |=> o_host_out_data == s_r.rx_src[23:16])
      else $error("receive frame address byte order wrong");
   AST_BCAST_ROUTE: assert property (i_ce && hif.hdr_valid && hif.dest == BCAST_ADDR
      |=> s_r.r_bc)
      else $error("all-ones destination not broadcast");
   AST_API_ROUTE: assert property (i_ce && hif.pay_valid && hif.pay_ready && !hif.pay_raw
      |=> o_rf_tx_dest == $past(s_r.r_dest) && o_rf_tx_attempts == $past(s_r.r_att))
      else $error("framed byte not routed by its header");
   AST_BAUD_DEF: assert property (i_ce && !s_r.loaded && !i_cfg_baud_set
      |=> o_baud_rate == DEF_BAUD)
      else $error("default rate not applied");
   AST_CFG_FROZEN: assert property (s_r.loaded |=> $stable(s_r.c_stat) && $stable(s_r.c_mode)
      && $stable(s_r.c_rxapi) && $stable(s_r.baud))
      else $error("configuration changed outside reset");
endmodule : radio_host_api_framer

// ### verilog/api_framer_pkg.sv
// Constants, codes and state types shared by the host API framer modules
package api_framer_pkg;
   localparam logic [7:0] TAG_FRAME = 8'h81;
   localparam logic [7:0] TAG_STATUS = 8'h82;
   localparam logic [7:0] RES_FAIL = 8'h00;
   localparam logic [7:0] RES_OK = 8'h01;
   localparam logic [7:0] LEN_MIN = 8'h01;
   localparam logic [7:0] LEN_MAX = 8'h80;
   localparam logic [23:0] BCAST_ADDR = 24'hFFFFFF;
   localparam logic [23:0] DEF_BAUD = 24'h00E100;
   localparam logic [2:0] STAT_LAST_IDX = 3'h3;
   localparam logic [2:0] RXHDR_LAST_IDX = 3'h6;
   localparam logic [1:0] MODE_BCAST = 2'h0;
   localparam logic [1:0] MODE_AUTO = 2'h1;
   localparam logic [1:0] MODE_FIXED = 2'h2;

   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_STAT = 4'h2,
      H_RXHDR = 4'h4,
      H_RXPAY = 4'h8
   } host_st_t;

   typedef enum logic [7:0] {
      P_IDLE = 8'h01,
      P_LEN = 8'h02,
      P_SES = 8'h04,
      P_ATT = 8'h08,
      P_A2 = 8'h10,
      P_A1 = 8'h20,
      P_A0 = 8'h40,
      P_PAY = 8'h80
   } parse_st_t;
endpackage : api_framer_pkg

// ### verilog/tx_hdr_if.sv
// Parsed transmit header and payload bytes from the parser to the framer
`timescale 1ns/10ps
interface tx_hdr_if;
   logic hdr_valid;
   logic [7:0] session;
   logic [7:0] attempts;
   logic [23:0] dest;
   logic pay_valid;
   logic pay_raw;
   logic pay_last;
   logic [7:0] pay_data;
   logic pay_ready;
   modport parser(output hdr_valid, session, attempts, dest, pay_valid, pay_raw, pay_last,
      pay_data, input pay_ready);
   modport framer(input hdr_valid, session, attempts, dest, pay_valid, pay_raw, pay_last,
      pay_data, output pay_ready);
endinterface : tx_hdr_if

// ### verilog/tx_frame_parser.sv
// Splits the host byte stream into transmit headers and payload bytes
`timescale 1ns/10ps
module tx_frame_parser
   import api_framer_pkg::*;
#(
   parameter int MAX_LEN = 128
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic api_en,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic byte_ready,
   tx_hdr_if.parser hif
);
   typedef struct packed {
      parse_st_t st;
      logic rdy;
      logic hv;
      logic [7:0] ses;
      logic [7:0] att;
      logic [7:0] cnt;
      logic [23:0] dest;
      logic pv;
      logic praw;
      logic plast;
      logic [7:0] pd;
   } pstate_t;

   pstate_t s_r;
   pstate_t s_nxt;
   logic take;

   if (MAX_LEN < 1 || MAX_LEN > 255) begin : g_bad_len
      $error("MAX_LEN must lie in 1..255");
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.hv = 1'b0;
      take = byte_valid && s_r.rdy;
      if (s_r.pv && hif.pay_ready) begin
         s_nxt.pv = 1'b0;
      end
      if (take) begin
         case (s_r.st)
            P_IDLE: begin
               // Anything not opening a frame goes out under the configured route
               if (api_en && byte_data == TAG_FRAME) begin
                  s_nxt.st = P_LEN;
               end else begin
                  s_nxt.pv = 1'b1;
                  s_nxt.pd = byte_data;
                  s_nxt.praw = 1'b1;
                  s_nxt.plast = 1'b1;
               end
            end
            P_LEN: begin
               // Bad length drops the tag and length; the bytes after it go out raw until the next tag
               if (byte_data < LEN_MIN || byte_data > 8'(MAX_LEN)) begin
                  s_nxt.st = P_IDLE;
               end else begin
                  s_nxt.cnt = byte_data;
                  s_nxt.st = P_SES;
               end
            end
            P_SES: begin
               s_nxt.ses = byte_data;
               s_nxt.st = P_ATT;
            end
            P_ATT: begin
               s_nxt.att = byte_data;
               s_nxt.st = P_A2;
            end
            P_A2: begin
               s_nxt.dest[23:16] = byte_data;
               s_nxt.st = P_A1;
            end
            P_A1: begin
               s_nxt.dest[15:8] = byte_data;
               s_nxt.st = P_A0;
            end
            P_A0: begin
               s_nxt.dest[7:0] = byte_data;
               s_nxt.hv = 1'b1;
               s_nxt.st = P_PAY;
            end
            P_PAY: begin
               s_nxt.pv = 1'b1;
               s_nxt.pd = byte_data;
               s_nxt.praw = 1'b0;
               s_nxt.plast = (s_r.cnt == 8'h01);
               s_nxt.cnt = s_r.cnt - 8'h01;
               if (s_r.cnt == 8'h01) begin
                  s_nxt.st = P_IDLE;
               end
            end
            default: s_nxt.st = P_IDLE;
         endcase
      end
      // One byte of holding; ready is registered so the host sees a clean flop
      s_nxt.rdy = !s_nxt.pv;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_r <= '{st: P_IDLE, default: '0};
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign byte_ready = s_r.rdy;
   assign hif.hdr_valid = s_r.hv;
   assign hif.session = s_r.ses;
   assign hif.attempts = s_r.att;
   assign hif.dest = s_r.dest;
   assign hif.pay_valid = s_r.pv;
   assign hif.pay_raw = s_r.praw;
   assign hif.pay_last = s_r.plast;
   assign hif.pay_data = s_r.pd;
endmodule : tx_frame_parser

// ### bench/host_model.sv
// Host controller model: sends framed or raw bytes, collects block replies
`timescale 1ns/10ps
module host_model
   import api_framer_pkg::*;
(
   // Clock
   input wire logic i_clk,
   // Host to block
   output logic o_valid,
   output logic [7:0] o_data,
   input wire logic i_ready,
   // Block to host
   input wire logic i_out_valid,
   input wire logic [7:0] i_out_data,
   output logic o_out_ready
);
   logic [7:0] rx_q[$];
   logic [1:0] slow_r = 2'h0;
   initial begin
      o_valid = 1'b0;
      o_data = 8'h5A;
      o_out_ready = 1'b0;
   end
   // Slow reader, one cycle in four not ready
   always @(negedge i_clk) begin
      slow_r <= slow_r + 2'h1;
      o_out_ready <= (slow_r != 2'h3);
   end
   // Failure reports are kept like any other
   always @(posedge i_clk) begin
      if (i_out_valid && o_out_ready) begin
         rx_q.push_back(i_out_data);
      end
   end
   // Entered at a falling edge; each byte held until taken
   task automatic send(input logic [7:0] b[$]);
      foreach (b[k]) begin
         o_valid = 1'b1;
         o_data = b[k];
         while (!i_ready) @(negedge i_clk);
         @(posedge i_clk);
         @(negedge i_clk);
      end
      o_valid = 1'b0;
      o_data = ~o_data;
   endtask : send
   task automatic send_frame(input logic [7:0] ses, att, input logic [23:0] dst,
      input logic [7:0] pay[$]);
      logic [7:0] f[$];
      f = '{TAG_FRAME, 8'(pay.size()), ses, att, dst[23:16], dst[15:8], dst[7:0]};
      send({f, pay});
   endtask : send_frame
endmodule : host_model

// ### bench/tb.sv
// Self-checking bench for the host API framer
`timescale 1ns/10ps
module tb;
   import api_framer_pkg::*;
   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic [23:0] dest;
      logic bcast;
      logic [7:0] att;
      logic [7:0] ses;
   } rf_byte_t;
   logic i_sys_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_ce = 1'b1;
   logic i_cfg_tx_api_en, i_cfg_status_en, i_cfg_rx_api_en, i_cfg_baud_set;
   logic [1:0] i_cfg_route_mode;
   logic [23:0] i_cfg_dest_addr, i_cfg_baud_rate, o_baud_rate;
   logic [7:0] i_cfg_max_retries, i_cfg_bcast_attempts;
   logic i_host_in_valid, o_host_in_ready, o_host_out_valid, i_host_out_ready;
   logic [7:0] i_host_in_data, o_host_out_data;
   logic o_rf_tx_valid, o_rf_tx_last, o_rf_tx_bcast, i_rf_tx_ready = 1'b0;
   logic [7:0] o_rf_tx_data, o_rf_tx_attempts, o_rf_tx_session;
   logic [23:0] o_rf_tx_dest;
   logic i_tx_done = 1'b0, i_tx_acked = 1'b0, i_tx_was_bcast = 1'b0;
   logic [7:0] i_tx_remote_heard_local_strength = 8'h00;
   logic [7:0] i_tx_local_heard_remote_strength = 8'h00;
   logic i_rx_start = 1'b0, o_rx_hdr_ready, i_rx_valid = 1'b0, o_rx_ready;
   logic [7:0] i_rx_len = 8'h00, i_rx_data = 8'h00;
   logic [7:0] i_rx_remote_heard_local_strength = 8'h00;
   logic [7:0] i_rx_local_heard_remote_strength = 8'h00;
   logic [23:0] i_rx_src_addr = 24'h000000;
   rf_byte_t rf_q[$];
   int n_fail = 0;
   int total_checks = 0;
   int cycles = 0;
   always #10 i_sys_clk = ~i_sys_clk;
   radio_host_api_framer #(.MAX_LEN(128)) i_radio_host_api_framer (
      .i_sys_clk, .i_nrst, .i_ce, .i_cfg_tx_api_en, .i_cfg_status_en, .i_cfg_rx_api_en,
      .i_cfg_route_mode, .i_cfg_dest_addr, .i_cfg_max_retries, .i_cfg_bcast_attempts,
      .i_cfg_baud_set, .i_cfg_baud_rate, .o_baud_rate, .i_host_in_valid, .i_host_in_data,
      .o_host_in_ready, .o_host_out_valid, .o_host_out_data, .i_host_out_ready,
      .o_rf_tx_valid, .o_rf_tx_data, .o_rf_tx_last, .o_rf_tx_dest, .o_rf_tx_bcast,
      .o_rf_tx_attempts, .o_rf_tx_session, .i_rf_tx_ready, .i_tx_done, .i_tx_acked,
      .i_tx_was_bcast, .i_tx_remote_heard_local_strength, .i_tx_local_heard_remote_strength,
      .i_rx_start, .i_rx_len, .i_rx_remote_heard_local_strength,
      .i_rx_local_heard_remote_strength, .i_rx_src_addr, .o_rx_hdr_ready, .i_rx_valid,
      .i_rx_data, .o_rx_ready);
   host_model i_host_model (.i_clk(i_sys_clk), .o_valid(i_host_in_valid),
      .o_data(i_host_in_data), .i_ready(o_host_in_ready), .i_out_valid(o_host_out_valid),
      .i_out_data(o_host_out_data), .o_out_ready(i_host_out_ready));
   // Radio stalls one cycle in three
   always @(negedge i_sys_clk) i_rf_tx_ready <= (cycles % 3 != 0);
   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (o_rf_tx_valid && i_rf_tx_ready) begin
         rf_q.push_back({o_rf_tx_data, o_rf_tx_last, o_rf_tx_dest, o_rf_tx_bcast,
            o_rf_tx_attempts, o_rf_tx_session});
      end
      if (cycles == 20000) begin
         $display("Error at %0t: run timed out", $time);
         n_fail++;
         stop_test();
      end
   end
   task automatic chk_byte(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: byte %h, expected %h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_word(input logic [23:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_rf(input rf_byte_t got, exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: radio byte %h, expected %h", $time, got, exp);
      end
   endtask : chk_rf
   task automatic rf_expect(input rf_byte_t e);
      repeat (300) if (rf_q.size() == 0) @(negedge i_sys_clk);
      if (rf_q.size() == 0) rf_q.push_back('x);
      chk_rf(rf_q.pop_front(), e);
   endtask : rf_expect
   task automatic host_expect(input logic [7:0] e[$]);
      repeat (400) if (i_host_model.rx_q.size() < e.size()) @(negedge i_sys_clk);
      foreach (e[k]) begin
         if (i_host_model.rx_q.size() == 0) i_host_model.rx_q.push_back(8'hXX);
         chk_byte(i_host_model.rx_q.pop_front(), e[k]);
      end
   endtask : host_expect
   task automatic radio_done(input logic ack, bc, input logic [7:0] rhl, lhr);
      {i_tx_done, i_tx_acked, i_tx_was_bcast} = {1'b1, ack, bc};
      {i_tx_remote_heard_local_strength, i_tx_local_heard_remote_strength} = {rhl, lhr};
      @(negedge i_sys_clk);
      i_tx_done = 1'b0;
      {i_tx_remote_heard_local_strength, i_tx_local_heard_remote_strength} = ~{rhl, lhr};
   endtask : radio_done
   task automatic radio_rx(input logic [23:0] src, input logic [7:0] rhl, lhr,
      input logic [7:0] pay[$]);
      while (!o_rx_hdr_ready) @(negedge i_sys_clk);
      {i_rx_start, i_rx_len, i_rx_src_addr} = {1'b1, 8'(pay.size()), src};
      {i_rx_remote_heard_local_strength, i_rx_local_heard_remote_strength} = {rhl, lhr};
      @(negedge i_sys_clk);
      {i_rx_start, i_rx_len, i_rx_src_addr} = {1'b0, ~i_rx_len, ~src};
      foreach (pay[k]) begin
         {i_rx_valid, i_rx_data} = {1'b1, pay[k]};
         while (!o_rx_ready) @(negedge i_sys_clk);
         @(posedge i_sys_clk);
         @(negedge i_sys_clk);
      end
      {i_rx_valid, i_rx_data} = {1'b0, ~i_rx_data};
   endtask : radio_rx
   // Configuration only counts when captured after reset
   task automatic restart(input logic [3:0] en, input logic [1:0] mode);
      {i_cfg_tx_api_en, i_cfg_status_en, i_cfg_rx_api_en, i_cfg_baud_set} = en;
      {i_cfg_route_mode, i_cfg_dest_addr, i_cfg_baud_rate} = {mode, 24'h3C5A69, 24'h002580};
      {i_cfg_max_retries, i_cfg_bcast_attempts} = {8'h04, 8'h07};
      i_nrst = 1'b0;
      repeat (16) @(negedge i_sys_clk);
      i_nrst = 1'b1;
      repeat (3) @(negedge i_sys_clk);
   endtask : restart
   task automatic end_test(input string name);
      repeat (40) @(negedge i_sys_clk);
      chk_byte(8'(rf_q.size()), 8'h00);
      chk_byte(8'(i_host_model.rx_q.size()), 8'h00);
      $display("Test %s finished", name);
   endtask : end_test
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      restart(4'hE, MODE_FIXED);
      chk_word(o_baud_rate, DEF_BAUD);
      i_host_model.send_frame(8'h05, 8'h03, 24'h123456, '{8'hA1, 8'hA2});
      rf_expect({8'hA1, 1'b0, 24'h123456, 1'b0, 8'h03, 8'h05});
      rf_expect({8'hA2, 1'b1, 24'h123456, 1'b0, 8'h03, 8'h05});
      i_host_model.send_frame(8'h06, 8'h02, BCAST_ADDR, '{8'hB7});
      rf_expect({8'hB7, 1'b1, BCAST_ADDR, 1'b1, 8'h02, 8'h06});
      i_host_model.send('{8'h33});
      rf_expect({8'h33, 1'b1, 24'h3C5A69, 1'b0, 8'h04, 8'h00});
      radio_done(1'b1, 1'b0, 8'h40, 8'h41);
      host_expect('{TAG_STATUS, RES_OK, 8'h40, 8'h41});
      radio_done(1'b0, 1'b0, 8'h42, 8'h43);
      host_expect('{TAG_STATUS, RES_FAIL, 8'h42, 8'h43});
      radio_done(1'b0, 1'b1, 8'h44, 8'h45);
      host_expect('{TAG_STATUS, RES_OK, 8'h44, 8'h45});
      radio_done(1'b1, 1'b0, 8'h50, 8'h51);
      radio_rx(24'hABCDEF, 8'h60, 8'h61, '{8'hC1, 8'hC2, 8'hC3});
      host_expect('{TAG_STATUS, RES_OK, 8'h50, 8'h51, TAG_FRAME, 8'h03, 8'h60, 8'h61,
         8'hAB, 8'hCD, 8'hEF, 8'hC1, 8'hC2, 8'hC3});
      end_test("all framing on");
      restart(4'h1, MODE_BCAST);
      chk_word(o_baud_rate, 24'h002580);
      {i_cfg_baud_set, i_cfg_status_en, i_cfg_baud_rate} = {1'b0, 1'b1, 24'h001C20};
      repeat (4) @(negedge i_sys_clk);
      chk_word(o_baud_rate, 24'h002580);
      radio_done(1'b1, 1'b0, 8'h70, 8'h71);
      radio_rx(24'h13579B, 8'h72, 8'h73, '{8'hD1, 8'hD2});
      host_expect('{8'hD1, 8'hD2});
      i_host_model.send('{TAG_FRAME});
      rf_expect({TAG_FRAME, 1'b1, BCAST_ADDR, 1'b1, 8'h07, 8'h00});
      end_test("all framing off");
      restart(4'hC, MODE_AUTO);
      i_host_model.send('{8'h21});
      rf_expect({8'h21, 1'b1, 24'h000000, 1'b0, 8'h04, 8'h00});
      radio_rx(24'h2468AC, 8'h74, 8'h75, '{8'hE1});
      host_expect('{8'hE1});
      i_host_model.send('{8'h44});
      rf_expect({8'h44, 1'b1, 24'h2468AC, 1'b0, 8'h04, 8'h00});
      radio_done(1'b0, 1'b0, 8'h76, 8'h77);
      host_expect('{TAG_STATUS, RES_FAIL, 8'h76, 8'h77});
      end_test("learned destination");
      stop_test();
   end
endmodule : tb
